// >>> rtl/pwrsc_top.sv
// Power-management and system-control register block with wakeup sequencer
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module pwrsc_top
    import pwrsc_pkg::*;
#(
    parameter int TMO_CYCLES    = TMO_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        NRST,
    // Register port
    input  wire logic [31:0] ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    // Power events
    input  wire logic        SLEEP_REQ,
    input  wire logic        WAKE_EVENT,
    input  wire logic        BLOCKS_READY,
    input  wire logic        COPY_DONE,
    input  wire logic        XTAL_ENABLE,
    input  wire logic [15:0] APPLIED_TRIM,
    input  wire logic        DBG_DOMAIN_UP,
    // Outputs to the system
    output logic      [3:0]  RAM_RETAIN,
    output logic             DCDC_BOOST,
    output logic             DCDC_BUCK,
    output logic             RADIO_OFF,
    output logic             PERIPHERAL_DOMAIN_OFF,
    output logic             SYSTEM_RESET_N,
    output logic      [1:0]  MIRROR_CLK_DIV,
    output logic             MIRROR_ACTIVE,
    output logic             MIRROR_WRITE_EN,
    output logic             DEBUG_PINS_TO_DBG,
    output logic             OTP_CTRL_RESET_REQUEST,
    output logic             PAD_LATCH_OPEN,
    output logic             SLOW_CLOCK_PICK,
    output logic      [1:0]  BOOT_REGION_SELECT,
    output logic             TRIM_APPLY,
    output logic      [15:0] CRYSTAL_FREQUENCY_TRIM
);
    logic [15:0] pmu, sys, trim, ftrim, rdata;
    logic [15:0] next_pmu, next_sys, next_trim, next_ftrim, next_rdata;
    logic        force_lock, next_force_lock;
    logic        dom_rst_n;
    logic [2:0]  swrst_cnt, next_swrst_cnt;
    pwrsc_state_e state, next_state;
    logic [31:0] tmo, next_tmo;
    logic        boost, buck, next_boost, next_buck;
    logic        trim_start, trim_done, settle_done;
    logic        settle_start, trim_done_q, next_trim_done_q;
    logic        xtal_q, stable, next_stable;
    logic [31:0] age, next_age;
    logic [15:0] stat;

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_comb begin
        next_pmu        = pmu;
        next_sys        = sys;
        next_trim       = trim;
        next_ftrim      = ftrim;
        next_force_lock = force_lock;
        next_swrst_cnt  = (swrst_cnt != 3'd0) ? swrst_cnt - 3'd1 : 3'd0;
        if (WR) begin
            case (ADDR)
                ADDR_PMU: begin
                    next_pmu = WDATA & PMU_MASK;
                    // Force bits lock once either has been written as one
                    if (force_lock) begin
                        next_pmu[BIT_BOOST] = pmu[BIT_BOOST];
                        next_pmu[BIT_BUCK]  = pmu[BIT_BUCK];
                    end else if (WDATA[BIT_BOOST] | WDATA[BIT_BUCK]) begin
                        next_force_lock = 1'b1;
                    end
                end
                ADDR_SYS: begin
                    next_sys = WDATA & SYS_MASK;
                    if (WDATA[BIT_SWRST]) begin
                        next_swrst_cnt = 3'(SWRST_CYC);
                    end
                end
                ADDR_TRIM:  next_trim  = WDATA & TRIM_MASK;
                ADDR_FTRIM: next_ftrim = WDATA;
                default: ;
            endcase
        end
    end

    // Software reset clears only the domain-reset registers; system
    // control and the frequency trim live on the power-on reset only.
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sys       <= SYS_RST;
            ftrim     <= FTRIM_RST;
            swrst_cnt <= 3'd0;
        end else begin
            sys       <= next_sys;
            ftrim     <= next_ftrim;
            swrst_cnt <= next_swrst_cnt;
        end
    end

    // Domain reset: power-on, software reset or reset-on-wakeup
    assign dom_rst_n = NRST & (swrst_cnt == 3'd0) &
                       (state != PWRSC_WRST);

    always_ff @(posedge MCLK or negedge dom_rst_n) begin
        if (!dom_rst_n) begin
            pmu        <= PMU_RST;
            trim       <= TRIM_RST;
            force_lock <= 1'b0;
        end else begin
            pmu        <= next_pmu;
            trim       <= next_trim;
            force_lock <= next_force_lock;
        end
    end

    // ----------------------------------------------------------------
    // Power sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_tmo   = tmo;
        next_boost = boost;
        next_buck  = buck;
        case (state)
            PWRSC_SLEEP: begin
                if (WAKE_EVENT) begin
                    next_tmo   = 32'd0;
                    // Converter mode is taken at wakeup, boost first
                    next_boost = pmu[BIT_BOOST];
                    next_buck  = pmu[BIT_BUCK] & ~pmu[BIT_BOOST];
                    next_state = pmu[0] ? PWRSC_WRST : PWRSC_START;
                end
            end
            PWRSC_WRST:  next_state = PWRSC_START;
            PWRSC_START: begin
                next_tmo = tmo + 32'd1;
                if (BLOCKS_READY ||
                    (!sys[9] && tmo >= 32'(TMO_CYCLES - 1))) begin
                    next_state = sys[4] ? PWRSC_COPY : PWRSC_RUN;
                end
            end
            PWRSC_COPY: if (COPY_DONE) next_state = PWRSC_RUN;
            PWRSC_RUN:  if (SLEEP_REQ) next_state = PWRSC_SLEEP;
            default:     next_state = PWRSC_RUN;
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state <= PWRSC_RUN;
            tmo   <= 32'd0;
            boost <= 1'b0;
            buck  <= 1'b0;
        end else begin
            state <= next_state;
            tmo   <= next_tmo;
            boost <= next_boost;
            buck  <= next_buck;
        end
    end

    // ----------------------------------------------------------------
    // Crystal trim and settling
    // ----------------------------------------------------------------
    assign trim_start = XTAL_ENABLE & ~xtal_q;
    // Settle wait runs from the moment the trim is applied
    assign settle_start = trim_done & ~trim_done_q;

    pwrsc_step_timer #(.STEP(STEP_CYC)) u_trim_delay (
        .clk   (MCLK),
        .rst_n (NRST),
        .start (trim_start),
        .steps (trim[7:4]),
        .done  (trim_done)
    );

    pwrsc_step_timer #(.STEP(STEP_CYC)) u_settle_delay (
        .clk   (MCLK),
        .rst_n (NRST),
        .start (settle_start),
        .steps (trim[3:0]),
        .done  (settle_done)
    );

    // Stable only after the trim wait, the settle wait and the 2 ms floor
    always_comb begin
        next_age    = age;
        next_stable = stable;
        // Cleared on a new enable so a stale done still gives an edge
        next_trim_done_q = trim_start ? 1'b0 : trim_done;
        if (!XTAL_ENABLE) begin
            next_age    = 32'd0;
            next_stable = 1'b0;
        end else begin
            if (age < 32'(SETTLE_CYCLES)) next_age = age + 32'd1;
            if (trim_done && trim_done_q && settle_done &&
                age >= 32'(SETTLE_CYCLES)) next_stable = 1'b1;
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            xtal_q      <= 1'b0;
            trim_done_q <= 1'b0;
            age    <= 32'd0;
            stable <= 1'b0;
        end else begin
            xtal_q      <= XTAL_ENABLE;
            trim_done_q <= next_trim_done_q;
            age    <= next_age;
            stable <= next_stable;
        end
    end

    // ----------------------------------------------------------------
    // Status and read port
    // ----------------------------------------------------------------
    always_comb begin
        stat    = 16'h0000;
        stat[7] = stable;
        stat[6] = (APPLIED_TRIM == ftrim);
        stat[5] = DBG_DOMAIN_UP;
        stat[4] = ~DBG_DOMAIN_UP;
        stat[3] = ~pmu[1] & (state != PWRSC_SLEEP);
        stat[2] = ~stat[3];
        stat[1] = ~pmu[2] & (state != PWRSC_SLEEP);
        stat[0] = ~stat[1];
        next_rdata = 16'h0000;
        if (RD) begin
            case (ADDR)
                ADDR_PMU:   next_rdata = pmu;
                ADDR_SYS:   next_rdata = sys;
                ADDR_STAT:  next_rdata = stat;
                ADDR_TRIM:  next_rdata = trim;
                ADDR_FTRIM: next_rdata = ftrim;
                default:    next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) rdata <= 16'h0000;
        else       rdata <= next_rdata;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign RDATA                  = rdata;
    assign RAM_RETAIN             = pmu[11:8];
    assign DCDC_BOOST             = boost;
    assign DCDC_BUCK              = buck;
    assign RADIO_OFF              = pmu[2];
    assign PERIPHERAL_DOMAIN_OFF  = pmu[1];
    assign SYSTEM_RESET_N         = dom_rst_n;
    assign MIRROR_ACTIVE          = (state == PWRSC_COPY);
    assign MIRROR_CLK_DIV         = MIRROR_ACTIVE ? pmu[5:4] : 2'b00;
    assign MIRROR_WRITE_EN        = MIRROR_ACTIVE & ~sys[2];
    assign DEBUG_PINS_TO_DBG      = sys[7];
    assign OTP_CTRL_RESET_REQUEST = sys[6];
    assign PAD_LATCH_OPEN         = sys[5];
    assign SLOW_CLOCK_PICK        = sys[3];
    assign BOOT_REGION_SELECT     = sys[1:0];
    assign TRIM_APPLY             = trim_done;
    assign CRYSTAL_FREQUENCY_TRIM = ftrim;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_force_lock;
        @(posedge MCLK) disable iff (!dom_rst_n)
        force_lock && WR && ADDR == ADDR_PMU |=> $stable(pmu[7:6]);
    endproperty
    a_force_lock: assert property (p_force_lock) else $error("force bits changed");

    property p_boost_wins;
        @(posedge MCLK) disable iff (!NRST)
        state == PWRSC_SLEEP && WAKE_EVENT && pmu[7] |=> boost && !buck;
    endproperty
    a_boost_wins: assert property (p_boost_wins) else $error("boost lost");

    property p_wake_reset;
        @(posedge MCLK) disable iff (!NRST)
        state == PWRSC_SLEEP && WAKE_EVENT && pmu[0] |=> !SYSTEM_RESET_N;
    endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("no wake reset");

    property p_swrst;
        @(posedge MCLK) disable iff (!NRST)
        WR && ADDR == ADDR_SYS && WDATA[15] |=> !SYSTEM_RESET_N [*4];
    endproperty
    a_swrst: assert property (p_swrst) else $error("software_full_reset short");

    property p_sys_kept;
        @(posedge MCLK) disable iff (!NRST)
        !SYSTEM_RESET_N && !(WR && ADDR == ADDR_SYS) |=> $stable(sys);
    endproperty
    a_sys_kept: assert property (p_sys_kept) else $error("sys lost");

    property p_copy_start;
        @(posedge MCLK) disable iff (!NRST)
        state == PWRSC_START && BLOCKS_READY && sys[4] |=> MIRROR_ACTIVE;
    endproperty
    a_copy_start: assert property (p_copy_start) else $error("no copy");

    property p_emul;
        @(posedge MCLK) disable iff (!NRST)
        MIRROR_ACTIVE && sys[2] |-> !MIRROR_WRITE_EN;
    endproperty
    a_emul: assert property (p_emul) else $error("emulation wrote");

    property p_read_zero;
        @(posedge MCLK) disable iff (!NRST)
        RD && ADDR == ADDR_PMU |=> RDATA[15:12] == 4'h0 && !RDATA[3];
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("unused bit set");

    property p_stable_floor;
        @(posedge MCLK) disable iff (!NRST)
        $rose(stable) |-> age >= 32'(SETTLE_CYCLES) && trim_done;
    endproperty
    a_stable_floor: assert property (p_stable_floor) else $error("early stable");
endmodule
`default_nettype wire

// >>> shared/pwrsc_pkg.sv
// Package of constants for the power and system control register block
// Behaviour
// - Four retention bits, one per RAM bank; set keeps bank, clear gates.
// - Force-boost bit 7 and force-buck bit 6 set converter mode at wakeup.
// - Boost wins when both set; after first write setting either, both force bits freeze.
// - Radio-sleep bit 2, reset one, holds digital radio powered down.
// - Peripheral-sleep bit 1, reset one, holds peripheral domain down.
// - Reset-after-wakeup bit 0 causes full hardware reset on waking.
// - Two-bit divider divides bus clock while mirroring runs.
// - Writing one to bit 15 resets device; system control and frequency trim kept.
// - Power sequencer proceeds after 2 ms unless timeout-disable bit 9 set.
// - Debug pins go to debugger only while debugger-enable bit 7 set.
// - Bit 6 of system control drives OTP controller reset request.
// - Pad-latch bit 5, reset one: zero freezes pad controls, one transparent.
// - Copy-enable bit 4 starts OTP-to-RAM copy after system domain wakes.
// - Bit 3 picks slow clock: zero RC oscillator, one crystal.
// - Emulation bit with copy enable spends full copy time without writing.
// - Two-bit remap field selects memory mapped at execution address zero.
// - Crystal-stable flag bit 7 set after more than 2 ms settling.
// - Trimmed flag bit 6, reset one, shows applied trim equals programmed.
// - Up and down flags for debug, peripheral, radio; downs reset to one.
// - Trim delay field, 250 us steps, reset 0xA, between enable and trim.
// - Settle field, 250 us steps, reset 0x2, after trim before stable flag.
package pwrsc_pkg;
    localparam logic [31:0] ADDR_PMU   = 32'h5000_0010;
    localparam logic [31:0] ADDR_SYS   = 32'h5000_0012;
    localparam logic [31:0] ADDR_STAT  = 32'h5000_0014;
    localparam logic [31:0] ADDR_TRIM  = 32'h5000_0016;
    localparam logic [31:0] ADDR_FTRIM = 32'h5000_0018;
    // Writable masks of the PMU, system control and trim registers
    localparam logic [15:0] PMU_MASK   = 16'h0FF7;
    localparam logic [15:0] SYS_MASK   = 16'h02FF;
    localparam logic [15:0] TRIM_MASK  = 16'h00FF;
    localparam logic [15:0] PMU_RST    = 16'h0006;
    localparam logic [15:0] SYS_RST    = 16'h0020;
    localparam logic [15:0] TRIM_RST   = 16'h00A2;
    localparam logic [15:0] FTRIM_RST  = 16'h0000;
    localparam int BIT_SWRST    = 15;
    localparam int BIT_BOOST    = 7;
    localparam int BIT_BUCK     = 6;
    // Time base: 40 MHz clock
    localparam int CLK_MHZ      = 40;
    localparam int STEP_US      = 250;
    localparam int STEP_CYC     = STEP_US * CLK_MHZ;
    localparam int TMO_US       = 2000;
    localparam int TMO_CYC      = TMO_US * CLK_MHZ;
    localparam int SETTLE_US    = 2000;
    localparam int SETTLE_CYC   = SETTLE_US * CLK_MHZ;
    localparam int SWRST_CYC    = 4;
    typedef enum logic [2:0] {
        PWRSC_SLEEP  = 3'b000,
        PWRSC_START  = 3'b001,
        PWRSC_COPY   = 3'b010,
        PWRSC_RUN    = 3'b011,
        PWRSC_WRST   = 3'b100
    } pwrsc_state_e;
endpackage

// >>> rtl/pwrsc_step_timer.sv
// Step timer counting a programmed number of fixed-length time steps
`timescale 1ns/1ps
`default_nettype none
module pwrsc_step_timer #(
    parameter int STEP = 10000
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [3:0] steps,
    output logic            done
);
    logic [3:0]  left;
    logic [15:0] sub;
    logic        run;
    logic [3:0]  next_left;
    logic [15:0] next_sub;
    logic        next_run;
    logic        next_done;

    always_comb begin
        next_left = left;
        next_sub  = sub;
        next_run  = run;
        next_done = done;
        if (start) begin
            next_done = (steps == 4'h0);
            next_run  = (steps != 4'h0);
            next_left = steps;
            next_sub  = 16'(STEP - 1);
        end else if (run) begin
            if (sub == 16'h0000) begin
                next_sub = 16'(STEP - 1);
                if (left == 4'h1) begin
                    next_run  = 1'b0;
                    next_done = 1'b1;
                end
                next_left = left - 4'h1;
            end else begin
                next_sub = sub - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 4'h0;
            sub  <= 16'h0000;
            run  <= 1'b0;
            done <= 1'b0;
        end else begin
            left <= next_left;
            sub  <= next_sub;
            run  <= next_run;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// >>> verification/pwrsc_top_tb_top.sv
// Self-checking testbench of the power and system control register block
`timescale 1ns/1ps
`default_nettype none
module pwrsc_top_tb_top;
    import pwrsc_pkg::*;
    // ------------------------------------------------------------
    // Shortened counts so the run stays short
    // ------------------------------------------------------------
    localparam int TMO = 50;
    localparam int SET = 50;
    localparam logic [31:0] ADDR_NONE = 32'h5000_001A;
    logic        MCLK = 1'b0;
    logic        NRST = 1'b0;
    logic [31:0] ADDR = 32'h0000_0000;
    logic [15:0] WDATA = 16'h0000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [15:0] RDATA;
    logic        SLEEP_REQ = 1'b0;
    logic        WAKE_EVENT = 1'b0;
    logic        BLOCKS_READY = 1'b1;
    logic        COPY_DONE = 1'b0;
    logic        XTAL_ENABLE = 1'b0;
    logic [15:0] APPLIED_TRIM = 16'h0000;
    logic        DBG_DOMAIN_UP = 1'b0;
    logic [3:0]  RAM_RETAIN;
    logic        DCDC_BOOST, DCDC_BUCK, RADIO_OFF, PERIPHERAL_DOMAIN_OFF;
    logic        SYSTEM_RESET_N, MIRROR_ACTIVE, MIRROR_WRITE_EN;
    logic [1:0]  MIRROR_CLK_DIV, BOOT_REGION_SELECT;
    logic        DEBUG_PINS_TO_DBG, OTP_CTRL_RESET_REQUEST, PAD_LATCH_OPEN;
    logic        SLOW_CLOCK_PICK, TRIM_APPLY;
    logic [15:0] CRYSTAL_FREQUENCY_TRIM;
    integer      seed = 71;
    int          num_errors = 0;
    int          checked = 0;
    int          i, k, n;
    logic [15:0] d, r, s, f, t;

    always #12.5 MCLK = ~MCLK;

    pwrsc_top #(.TMO_CYCLES(TMO), .SETTLE_CYCLES(SET)) u_pwrsc_top (
        .MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .SLEEP_REQ(SLEEP_REQ),
        .WAKE_EVENT(WAKE_EVENT), .BLOCKS_READY(BLOCKS_READY),
        .COPY_DONE(COPY_DONE), .XTAL_ENABLE(XTAL_ENABLE),
        .APPLIED_TRIM(APPLIED_TRIM), .DBG_DOMAIN_UP(DBG_DOMAIN_UP),
        .RAM_RETAIN(RAM_RETAIN), .DCDC_BOOST(DCDC_BOOST),
        .DCDC_BUCK(DCDC_BUCK), .RADIO_OFF(RADIO_OFF),
        .PERIPHERAL_DOMAIN_OFF(PERIPHERAL_DOMAIN_OFF),
        .SYSTEM_RESET_N(SYSTEM_RESET_N), .MIRROR_CLK_DIV(MIRROR_CLK_DIV),
        .MIRROR_ACTIVE(MIRROR_ACTIVE), .MIRROR_WRITE_EN(MIRROR_WRITE_EN),
        .DEBUG_PINS_TO_DBG(DEBUG_PINS_TO_DBG),
        .OTP_CTRL_RESET_REQUEST(OTP_CTRL_RESET_REQUEST),
        .PAD_LATCH_OPEN(PAD_LATCH_OPEN), .SLOW_CLOCK_PICK(SLOW_CLOCK_PICK),
        .BOOT_REGION_SELECT(BOOT_REGION_SELECT), .TRIM_APPLY(TRIM_APPLY),
        .CRYSTAL_FREQUENCY_TRIM(CRYSTAL_FREQUENCY_TRIM)
    );

    // ------------------------------------------------------------
    // Checking, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic to_fail();
        num_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h (wait ran out)", $time, 0, 1);
        close_out();
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] v);
        @(posedge MCLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [15:0] v);
        @(posedge MCLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge MCLK);
        RD   <= 1'b0;
        #1 v = RDATA;
    endtask

    task automatic sleep_wake();
        @(posedge MCLK);
        SLEEP_REQ  <= 1'b1;
        @(posedge MCLK);
        SLEEP_REQ  <= 1'b0;
        WAKE_EVENT <= 1'b1;
        @(posedge MCLK);
        WAKE_EVENT <= 1'b0;
    endtask

    // Counts low cycles of the system reset over a fixed window
    task automatic count_low(output int c);
        c = 0;
        for (int j = 0; j < 10; j++) begin
            #1 if (SYSTEM_RESET_N === 1'b0) c++;
            @(posedge MCLK);
        end
    endtask

    // Bounded wait on mirroring (sel 0) or trim applied (sel 1)
    task automatic wait_sig(input logic sel, input logic v,
                            input int bound, output int c);
        c = 0;
        #1;
        while ((sel ? TRIM_APPLY : MIRROR_ACTIVE) !== v && c < bound) begin
            @(posedge MCLK);
            #1 c++;
        end
        if ((sel ? TRIM_APPLY : MIRROR_ACTIVE) !== v) to_fail();
    endtask

    function automatic logic [15:0] exp_stat(input logic [15:0] p,
        input logic dbg, input logic eq, input logic st);
        return {8'h00, st, eq, dbg, ~dbg, ~p[1], p[1], ~p[2], p[2]};
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge MCLK);
        NRST <= 1'b1;
        rd(ADDR_PMU, r);   chk(r, PMU_RST);
        @(posedge MCLK);
        #1 chk(RDATA, 16'h0000);
        rd(ADDR_SYS, r);   chk(r, SYS_RST);
        rd(ADDR_STAT, r);  chk(r, exp_stat(PMU_RST, 0, 1, 0));
        rd(ADDR_TRIM, r);  chk(r, TRIM_RST);
        rd(ADDR_FTRIM, r); chk(r, FTRIM_RST);
        wr(ADDR_NONE, 16'hFFFF);
        rd(ADDR_NONE, r);  chk(r, 16'h0000);
        chk({RADIO_OFF, PERIPHERAL_DOMAIN_OFF, PAD_LATCH_OPEN}, 3'b111);
        $display("test reset_values done");
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            d[7:6] = 2'b00;
            wr(ADDR_PMU, d);
            rd(ADDR_PMU, r); chk(r, d & PMU_MASK);
            chk({12'h000, RAM_RETAIN}, {12'h000, d[11:8]});
            chk({RADIO_OFF, PERIPHERAL_DOMAIN_OFF}, d[2:1]);
            s = $random(seed);
            s[1:0] = i[1:0];
            s[15] = 1'b0;
            wr(ADDR_SYS, s);
            rd(ADDR_SYS, r); chk(r, s & SYS_MASK);
            chk({DEBUG_PINS_TO_DBG, OTP_CTRL_RESET_REQUEST}, s[7:6]);
            chk({PAD_LATCH_OPEN, SLOW_CLOCK_PICK}, {s[5], s[3]});
            chk({14'h0000, BOOT_REGION_SELECT}, {14'h0000, s[1:0]});
            f = $random(seed);
            wr(ADDR_FTRIM, f);
            APPLIED_TRIM  <= f ^ {15'h0000, i[0]};
            DBG_DOMAIN_UP <= i[1];
            wr(ADDR_STAT, 16'hFFFF);
            rd(ADDR_STAT, r); chk(r, exp_stat(d, i[1], ~i[0], 0));
            chk(CRYSTAL_FREQUENCY_TRIM, f);
            t = $random(seed);
            wr(ADDR_TRIM, t);
            rd(ADDR_TRIM, r); chk(r, t & TRIM_MASK);
        end
        $display("test random_registers done");
        // Each pass writes the registers, then issues a software reset that also frees the force lock
        for (k = 0; k < 2; k++) begin
            s = 16'h00A9;
            f = 16'h3C5A + k;
            wr(ADDR_PMU, 16'h0F26);
            wr(ADDR_TRIM, 16'h0055);
            wr(ADDR_FTRIM, f);
            wr(ADDR_SYS, s | 16'h8000);
            count_low(n); chk(n, SWRST_CYC);
            rd(ADDR_PMU, r);   chk(r, PMU_RST);
            rd(ADDR_TRIM, r);  chk(r, TRIM_RST);
            rd(ADDR_SYS, r);   chk(r, s);
            rd(ADDR_FTRIM, r); chk(r, f);
            d = k ? 16'h00C6 : 16'h0046;
            wr(ADDR_PMU, d);
            wr(ADDR_PMU, k ? 16'h0006 : 16'h00C6);
            rd(ADDR_PMU, r);   chk(r, d);
            sleep_wake();
            repeat (4) @(posedge MCLK);
            #1 chk({DCDC_BOOST, DCDC_BUCK}, k ? 2'b10 : 2'b01);
        end
        $display("test soft_reset_and_force done");
        wr(ADDR_SYS, 16'h0020);
        wr(ADDR_PMU, 16'h0007);
        sleep_wake();
        count_low(n); chk(n, 1);
        wr(ADDR_PMU, 16'h0026);
        $display("test reset_on_wake done");
        for (k = 0; k < 2; k++) begin
            wr(ADDR_SYS, 16'h0030 | (k << 2));
            sleep_wake();
            wait_sig(0, 1, 20, n);
            chk({MIRROR_CLK_DIV, MIRROR_WRITE_EN}, {2'b10, ~k[0]});
            @(posedge MCLK);
            COPY_DONE <= 1'b1;
            @(posedge MCLK);
            COPY_DONE <= 1'b0;
            wait_sig(0, 0, 20, n);
            chk({14'h0000, MIRROR_CLK_DIV}, 16'h0000);
        end
        $display("test mirroring done");
        BLOCKS_READY <= 1'b0;
        wr(ADDR_SYS, 16'h0030);
        sleep_wake();
        wait_sig(0, 1, 3 * TMO, n);
        chk(n >= TMO - 4 && n <= TMO + 6, 16'h0001);
        COPY_DONE <= 1'b1;
        @(posedge MCLK);
        COPY_DONE <= 1'b0;
        wr(ADDR_SYS, 16'h0230);
        sleep_wake();
        repeat (3 * TMO) @(posedge MCLK);
        #1 chk(MIRROR_ACTIVE, 16'h0000);
        BLOCKS_READY <= 1'b1;
        wait_sig(0, 1, 20, n);
        COPY_DONE <= 1'b1;
        @(posedge MCLK);
        COPY_DONE <= 1'b0;
        $display("test power_timeout done");
        APPLIED_TRIM <= 16'h0000;
        wr(ADDR_FTRIM, 16'h0000);
        wr(ADDR_TRIM, 16'h0000);
        XTAL_ENABLE <= 1'b1;
        wait_sig(1, 1, 5, n);
        repeat (SET - 20) @(posedge MCLK);
        rd(ADDR_STAT, r); chk(r[7], 1'b0);
        n = 0;
        do begin
            rd(ADDR_STAT, r);
            n++;
        end while (r[7] !== 1'b1 && n < 40);
        chk(r[7], 1'b1);
        XTAL_ENABLE <= 1'b0;
        rd(ADDR_STAT, r);
        rd(ADDR_STAT, r); chk(r[7], 1'b0);
        wr(ADDR_TRIM, 16'h0010);
        XTAL_ENABLE <= 1'b1;
        repeat (STEP_CYC - 1000) @(posedge MCLK);
        #1 chk(TRIM_APPLY, 16'h0000);
        rd(ADDR_STAT, r); chk(r[7], 1'b0);
        wait_sig(1, 1, 2000, n);
        repeat (4) @(posedge MCLK);
        rd(ADDR_STAT, r); chk(r[7], 1'b1);
        $display("test crystal_timing done");
        close_out();
    end
endmodule
`default_nettype wire
